// >>> logic/gkp_pkg.sv
// constants and register map for the keypad-shared general-purpose ports
//--------------------------------------------------------------------------
// Notes on behaviour
//--------------------------------------------------------------------------
// Notes on behaviour
// RULE1: direction bit 1 enables pin output buffer, 0 leaves the pin an input.
// RULE2: reset clears all three direction bits of the three-bit port.
// RULE3: reset clears both direction bits of the two-bit port.
// RULE4: three-bit data read gives latch where direction is 1, pin level where 0.
// RULE5: two-bit data read gives latch where direction is 1, pin level where 0.
// RULE6: data writes always update latches; input pins keep reading the pin.
// RULE7: reset leaves the two-bit port data latches untouched.
// RULE8: direction bits read back exactly the value last written.
// RULE9: keypad enables for positions 4 and 3 make two-bit pins interrupt inputs.
// RULE10: software should load the latch before turning a direction bit to output.
// RULE11: keypad enables for positions 2 to 0 override three-bit port directions.
// RULE12: reset leaves three-bit data latches untouched; they are read/write.
// RULE13: unimplemented upper data and direction bits ignore writes, read zero.
package gkp_pkg;

    //----------------------------------------------------------------------
    // port widths
    //----------------------------------------------------------------------
    localparam int GKP_THREE_W = 3;
    localparam int GKP_TWO_W = 2;
    localparam int GKP_KPD_W = 5;
    localparam int GKP_KPD_TWO_LSB = 3;

    //----------------------------------------------------------------------
    // register indices, byte address is four times the index
    //----------------------------------------------------------------------
    localparam logic [7:0] GKP_IDX_THREE_DATA = 8'h0A;
    localparam logic [7:0] GKP_IDX_TWO_DATA = 8'h0B;
    localparam logic [7:0] GKP_IDX_THREE_DIR = 8'h0E;
    localparam logic [7:0] GKP_IDX_TWO_DIR = 8'h0F;
    localparam logic [7:0] GKP_IDX_KPD_EN = 8'h10;
    localparam int GKP_ADDR_W = 8;
    localparam logic [7:0] GKP_ADDR_THREE_DATA = 8'(GKP_IDX_THREE_DATA << 2);
    localparam logic [7:0] GKP_ADDR_TWO_DATA = 8'(GKP_IDX_TWO_DATA << 2);
    localparam logic [7:0] GKP_ADDR_THREE_DIR = 8'(GKP_IDX_THREE_DIR << 2);
    localparam logic [7:0] GKP_ADDR_TWO_DIR = 8'(GKP_IDX_TWO_DIR << 2);
    localparam logic [7:0] GKP_ADDR_KPD_EN = 8'(GKP_IDX_KPD_EN << 2);

    //----------------------------------------------------------------------
    // values after reset
    //----------------------------------------------------------------------
    localparam logic [2:0] GKP_THREE_DIR_RST = 3'h0;
    localparam logic [1:0] GKP_TWO_DIR_RST = 2'h0;
    localparam logic [4:0] GKP_KPD_EN_RST = 5'h00;
    localparam logic [31:0] GKP_RDATA_RST = 32'h0000_0000;

endpackage : gkp_pkg

// >>> logic/gkp_sync.sv
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module gkp_sync #(
    parameter int W = 3
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    // only the second stage is ever read
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge i_core_clk or posedge i_rst) begin
                if (i_rst) begin
                    meta_r[g] <= 1'b0;
                    sync_r[g] <= 1'b0;
                end else begin
                    meta_r[g] <= i_async[g];
                    sync_r[g] <= meta_r[g];
                end
            end
        end
    endgenerate

    assign o_sync = sync_r;
endmodule : gkp_sync

// >>> logic/gkp_port.sv
// one general-purpose port: data latch, direction bits, read mux, pad drive
`timescale 1ns/1ps
module gkp_port #(
    parameter int W = 3,
    parameter logic [W-1:0] DIR_RST = '0
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_wr_data,
    input wire logic i_wr_dir,
    input wire logic [W-1:0] i_wdata,
    input wire logic [W-1:0] i_pin_sync,
    input wire logic [W-1:0] i_kpd_en,
    output logic [W-1:0] o_dir,
    output logic [W-1:0] o_read,
    output logic [W-1:0] o_pad_out,
    output logic [W-1:0] o_pad_oe
);
    logic [W-1:0] latch_r;
    logic [W-1:0] dir_r;
    logic [W-1:0] oe_r;
    logic [W-1:0] oe_nxt;

    // latch has no reset on purpose: contents survive a reset
    always_ff @(posedge i_core_clk) begin
        if (i_wr_data) begin
            latch_r <= i_wdata; // RULE6 RULE7 RULE12
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            dir_r <= DIR_RST; // RULE2 RULE3
            oe_r <= '0;
        end else begin
            if (i_wr_dir) begin
                dir_r <= i_wdata; // RULE8
            end
            oe_r <= oe_nxt;
        end
    end

    // an enabled keypad input overrides the direction bit
    assign oe_nxt = dir_r & ~i_kpd_en; // RULE1 RULE9 RULE11
    assign o_read = (dir_r & latch_r) | (~dir_r & i_pin_sync); // RULE4 RULE5
    assign o_dir = dir_r;
    assign o_pad_oe = oe_r;
    assign o_pad_out = latch_r;
endmodule : gkp_port

// >>> logic/gkp_top.sv
// apb register slave and pads for the keypad-shared three-bit and two-bit ports
`timescale 1ns/1ps
module gkp_top (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [2:0] i_three_pin,
    output logic [2:0] o_three_out,
    output logic [2:0] o_three_oe,
    input wire logic [1:0] i_two_pin,
    output logic [1:0] o_two_out,
    output logic [1:0] o_two_oe,
    output logic [4:0] o_kpd_pin,
    output logic [4:0] o_kpd_en
);

    //----------------------------------------------------------------------
    // bus decode
    //----------------------------------------------------------------------
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic [4:0] kpd_en_r;
    logic access;
    logic done;
    logic wr_done;
    logic sel_three_data;
    logic sel_two_data;
    logic sel_three_dir;
    logic sel_two_dir;
    logic sel_kpd_en;
    logic sel_any;
    logic low_lane;

    assign access = i_psel & i_penable;
    // one wait state lets read data come straight from a flop
    assign done = access & pready_r;
    assign low_lane = i_pstrb[0];
    assign wr_done = done & i_pwrite & low_lane;
    assign sel_three_data = (i_paddr == gkp_pkg::GKP_ADDR_THREE_DATA);
    assign sel_two_data = (i_paddr == gkp_pkg::GKP_ADDR_TWO_DATA);
    assign sel_three_dir = (i_paddr == gkp_pkg::GKP_ADDR_THREE_DIR);
    assign sel_two_dir = (i_paddr == gkp_pkg::GKP_ADDR_TWO_DIR);
    assign sel_kpd_en = (i_paddr == gkp_pkg::GKP_ADDR_KPD_EN);
    assign sel_any = sel_three_data | sel_two_data | sel_three_dir | sel_two_dir | sel_kpd_en;

    //----------------------------------------------------------------------
    // pin synchronisers
    //----------------------------------------------------------------------
    logic [2:0] three_sync;
    logic [1:0] two_sync;

    gkp_sync #(.W(gkp_pkg::GKP_THREE_W)) u_sync_three (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_async(i_three_pin),
        .o_sync(three_sync)
    );

    gkp_sync #(.W(gkp_pkg::GKP_TWO_W)) u_sync_two (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_async(i_two_pin),
        .o_sync(two_sync)
    );

    //----------------------------------------------------------------------
    // ports
    //----------------------------------------------------------------------
    logic [2:0] three_dir;
    logic [2:0] three_read;
    logic [1:0] two_dir;
    logic [1:0] two_read;
    logic [2:0] kpd_three;
    logic [1:0] kpd_two;

    assign kpd_three = kpd_en_r[2:0];
    assign kpd_two = kpd_en_r[4:3];

    gkp_port #(.W(gkp_pkg::GKP_THREE_W), .DIR_RST(gkp_pkg::GKP_THREE_DIR_RST)) u_three (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_wr_data(wr_done & sel_three_data),
        .i_wr_dir(wr_done & sel_three_dir),
        .i_wdata(i_pwdata[2:0]),
        .i_pin_sync(three_sync),
        .i_kpd_en(kpd_three),
        .o_dir(three_dir),
        .o_read(three_read),
        .o_pad_out(o_three_out),
        .o_pad_oe(o_three_oe)
    );

    gkp_port #(.W(gkp_pkg::GKP_TWO_W), .DIR_RST(gkp_pkg::GKP_TWO_DIR_RST)) u_two (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_wr_data(wr_done & sel_two_data),
        .i_wr_dir(wr_done & sel_two_dir),
        .i_wdata(i_pwdata[1:0]),
        .i_pin_sync(two_sync),
        .i_kpd_en(kpd_two),
        .o_dir(two_dir),
        .o_read(two_read),
        .o_pad_out(o_two_out),
        .o_pad_oe(o_two_oe)
    );

    //----------------------------------------------------------------------
    // read mux, upper bits always zero
    //----------------------------------------------------------------------
    assign prdata_nxt = sel_three_data ? {29'h0, three_read} : // RULE4 RULE13
                        sel_two_data ? {30'h0, two_read} : // RULE5 RULE13
                        sel_three_dir ? {29'h0, three_dir} : // RULE8
                        sel_two_dir ? {30'h0, two_dir} : // RULE8
                        sel_kpd_en ? {27'h0, kpd_en_r} :
                        32'h0000_0000;

    //----------------------------------------------------------------------
    // registers
    //----------------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= gkp_pkg::GKP_RDATA_RST;
        end else begin
            pready_r <= access & ~pready_r;
            pslverr_r <= access & ~pready_r & ~sel_any;
            if (access & ~pready_r & ~i_pwrite) begin
                prdata_r <= prdata_nxt;
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            kpd_en_r <= gkp_pkg::GKP_KPD_EN_RST;
        end else if (wr_done & sel_kpd_en) begin
            kpd_en_r <= i_pwdata[4:0];
        end
    end

    assign o_prdata = prdata_r;
    assign o_pready = pready_r;
    assign o_pslverr = pslverr_r;
    // keypad logic sees synchronised levels of the shared pins
    assign o_kpd_pin = {two_sync, three_sync}; // RULE9 RULE11
    assign o_kpd_en = kpd_en_r;

    //----------------------------------------------------------------------
    // assertions
    //----------------------------------------------------------------------
    logic rd_done;
    assign rd_done = done & ~i_pwrite;

    property p_three_oe;
        @(posedge i_core_clk) disable iff (i_rst)
        (wr_done && sel_three_dir && kpd_three == 3'h0) ##1 (kpd_three == 3'h0)
            |=> o_three_oe == $past(i_pwdata[2:0], 2);
    endproperty
    a_three_oe: assert property (p_three_oe) else $error("three-bit oe mismatch"); // RULE1

    property p_three_rst;
        @(posedge i_core_clk) $past(i_rst) |-> three_dir == 3'h0 && o_three_oe == 3'h0;
    endproperty
    a_three_rst: assert property (p_three_rst) else $error("three-bit dir not cleared"); // RULE2

    property p_two_rst;
        @(posedge i_core_clk) $past(i_rst) |-> two_dir == 2'h0 && o_two_oe == 2'h0;
    endproperty
    a_two_rst: assert property (p_two_rst) else $error("two-bit dir not cleared"); // RULE3

    property p_three_read;
        @(posedge i_core_clk) disable iff (i_rst)
        (rd_done && sel_three_data) |-> o_prdata[2:0] == $past(three_read);
    endproperty
    a_three_read: assert property (p_three_read) else $error("three-bit read wrong"); // RULE4

    property p_two_read;
        @(posedge i_core_clk) disable iff (i_rst)
        (rd_done && sel_two_data) |-> o_prdata[1:0] == $past(two_read);
    endproperty
    a_two_read: assert property (p_two_read) else $error("two-bit read wrong"); // RULE5

    property p_latch_wr;
        @(posedge i_core_clk) disable iff (i_rst)
        (wr_done && sel_three_data) |=> o_three_out == $past(i_pwdata[2:0])
            && (three_read & three_dir) == (o_three_out & three_dir);
    endproperty
    a_latch_wr: assert property (p_latch_wr) else $error("latch write lost"); // RULE6 RULE12

    property p_dir_rw;
        @(posedge i_core_clk) disable iff (i_rst)
        (wr_done && sel_two_dir) |=> two_dir == $past(i_pwdata[1:0]);
    endproperty
    a_dir_rw: assert property (p_dir_rw) else $error("direction readback wrong"); // RULE8

    property p_kpd_two;
        @(posedge i_core_clk) disable iff (i_rst)
        (kpd_two != 2'h0) |=> (o_two_oe & $past(kpd_two)) == 2'h0;
    endproperty
    a_kpd_two: assert property (p_kpd_two) else $error("two-bit irq pin driven"); // RULE9

    property p_kpd_three;
        @(posedge i_core_clk) disable iff (i_rst)
        (kpd_three != 3'h0) |=> (o_three_oe & $past(kpd_three)) == 3'h0;
    endproperty
    a_kpd_three: assert property (p_kpd_three) else $error("three-bit irq pin driven"); // RULE11

    property p_upper_zero;
        @(posedge i_core_clk) disable iff (i_rst)
        o_pready |-> o_prdata[31:5] == 27'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set"); // RULE13

    property p_ready_pulse;
        @(posedge i_core_clk) disable iff (i_rst)
        (access && !pready_r) |=> o_pready ##1 !o_pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready not one cycle");

    property p_two_oe;
        @(posedge i_core_clk) disable iff (i_rst)
        (wr_done && sel_two_dir && kpd_two == 2'h0) ##1 (kpd_two == 2'h0)
            |=> o_two_oe == $past(i_pwdata[1:0], 2);
    endproperty
    a_two_oe: assert property (p_two_oe) else $error("two-bit oe mismatch"); // RULE1

    property p_dir_three;
        @(posedge i_core_clk) disable iff (i_rst)
        (wr_done && sel_three_dir) |=> three_dir == $past(i_pwdata[2:0]);
    endproperty
    a_dir_three: assert property (p_dir_three) else $error("three dir wrong"); // RULE8

    property p_latch_two;
        @(posedge i_core_clk) disable iff (i_rst)
        (wr_done && sel_two_data) |=> o_two_out == $past(i_pwdata[1:0])
            && (two_read & two_dir) == (o_two_out & two_dir);
    endproperty
    a_latch_two: assert property (p_latch_two) else $error("two latch lost"); // RULE6

    property p_kpd_en;
        @(posedge i_core_clk) disable iff (i_rst)
        (wr_done && sel_kpd_en) |=> o_kpd_en == $past(i_pwdata[4:0]);
    endproperty
    a_kpd_en: assert property (p_kpd_en) else $error("keypad enable write lost"); // RULE9 RULE11

    // a write with the low byte lane masked must leave every register alone
    property p_strb_low;
        @(posedge i_core_clk) disable iff (i_rst)
        (done && i_pwrite && !low_lane) |=> $stable(three_dir) && $stable(two_dir)
            && $stable(o_kpd_en) && $stable(o_three_out) && $stable(o_two_out);
    endproperty
    a_strb_low: assert property (p_strb_low) else $error("masked write took effect");

    property p_rdata_hold;
        @(posedge i_core_clk) disable iff (i_rst)
        !(access && !pready_r && !i_pwrite) |=> $stable(o_prdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed");

    property p_slverr;
        @(posedge i_core_clk) disable iff (i_rst)
        (access && !pready_r) |=> o_pslverr == !$past(sel_any);
    endproperty
    a_slverr: assert property (p_slverr) else $error("slave error flag wrong");

    property p_unmap_zero;
        @(posedge i_core_clk) disable iff (i_rst)
        (rd_done && !sel_any) |-> o_prdata == 32'h0000_0000;
    endproperty
    a_unmap_zero: assert property (p_unmap_zero) else $error("unmapped read set"); // RULE13

    // sync flops are cleared by reset, so only check once two clean edges have passed
    property p_pin_sync;
        @(posedge i_core_clk) disable iff (i_rst)
        (!$past(i_rst) && !$past(i_rst, 2)) |-> o_kpd_pin[2:0] == $past(i_three_pin, 2)
            && o_kpd_pin[4:3] == $past(i_two_pin, 2);
    endproperty
    a_pin_sync: assert property (p_pin_sync) else $error("pin sync wrong"); // RULE9 RULE11

    property p_oe_lag;
        @(posedge i_core_clk) disable iff (i_rst)
        1'b1 |=> o_three_oe == ($past(three_dir) & ~$past(kpd_three))
            && o_two_oe == ($past(two_dir) & ~$past(kpd_two));
    endproperty
    a_oe_lag: assert property (p_oe_lag) else $error("oe lag wrong"); // RULE1 RULE11

    c_three_wr: cover property (@(posedge i_core_clk) disable iff (i_rst)
        wr_done && sel_three_data);
    c_two_rd: cover property (@(posedge i_core_clk) disable iff (i_rst)
        rd_done && sel_two_data && two_dir != 2'h0);
    c_slverr: cover property (@(posedge i_core_clk) disable iff (i_rst) o_pslverr);
    c_kpd_override: cover property (@(posedge i_core_clk) disable iff (i_rst)
        (three_dir & kpd_three) != 3'h0);
    c_two_drive: cover property (@(posedge i_core_clk) disable iff (i_rst) o_two_oe != 2'h0);

endmodule : gkp_top

// >>> sim/gkp_board.sv
// board-side model of the port pins: pad drive wins, else the external source
`timescale 1ns/1ps
module gkp_board (
    input wire logic [2:0] i_three_out,
    input wire logic [2:0] i_three_oe,
    input wire logic [2:0] i_three_ext,
    input wire logic [1:0] i_two_out,
    input wire logic [1:0] i_two_oe,
    input wire logic [1:0] i_two_ext,
    output logic [2:0] o_three_pin,
    output logic [1:0] o_two_pin
);
    // the external source is a random pattern, so a released pin never holds a stale value
    assign o_three_pin = (i_three_oe & i_three_out) | (~i_three_oe & i_three_ext);
    assign o_two_pin = (i_two_oe & i_two_out) | (~i_two_oe & i_two_ext);
endmodule : gkp_board

// >>> sim/tb.sv
// self-checking bench for the keypad-shared ports over apb
`timescale 1ns/1ps
module tb;
    typedef struct packed {logic rd; logic err; logic [31:0] d;} gkp_note_t;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'h0;
    logic [2:0] ext3 = 3'h0, three_pin, o_three_out, o_three_oe;
    logic [1:0] ext2 = 2'h0, two_pin, o_two_out, o_two_oe;
    logic [31:0] o_prdata;
    logic o_pready, o_pslverr;
    logic [4:0] o_kpd_pin, o_kpd_en;
    int err_count = 0;
    int tests_run = 0;
    gkp_note_t q[$];
    gkp_note_t nt;

    always #4 i_core_clk = ~i_core_clk;

    gkp_top i_gkp_top (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .i_pstrb(pstrb), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_three_pin(three_pin), .o_three_out(o_three_out), .o_three_oe(o_three_oe),
        .i_two_pin(two_pin), .o_two_out(o_two_out), .o_two_oe(o_two_oe),
        .o_kpd_pin(o_kpd_pin), .o_kpd_en(o_kpd_en));
    gkp_board i_gkp_board (.i_three_out(o_three_out), .i_three_oe(o_three_oe),
        .i_three_ext(ext3), .i_two_out(o_two_out), .i_two_oe(o_two_oe), .i_two_ext(ext2),
        .o_three_pin(three_pin), .o_two_pin(two_pin));

    //----------------------------------------------------------------------
    // reporting
    //----------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    //----------------------------------------------------------------------
    // apb master: one idle cycle between transfers keeps each signal to one assignment per step
    //----------------------------------------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       input logic [3:0] st, input logic [31:0] ed, input logic ee);
        int n;
        @(posedge i_core_clk);
        q.push_back('{rd: !wr, err: ee, d: ed});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        pstrb <= st;
        @(posedge i_core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 20);
        if (o_pready !== 1'b1) begin
            err_count++;
            final_report();
        end else begin
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd, 4'hF, 32'h0000_0000, 1'b0);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ed);
        apb(1'b0, a, 32'h0000_0000, 4'hF, ed, 1'b0);
    endtask : rd

    // pin sync takes two edges and oe lags direction by one
    task automatic settle();
        repeat (4) @(posedge i_core_clk);
    endtask : settle

    // pre-edge values are sampled, so the design's own updates never race this
    always @(posedge i_core_clk) begin
        if (psel && penable && o_pready === 1'b1) begin
            if (q.size() == 0) begin
                err_count++;
            end else begin
                nt = q.pop_front();
                check(32'(o_pslverr), 32'(nt.err));
                if (nt.rd) begin
                    check(o_prdata, nt.d);
                end
            end
        end
    end

    initial begin
        #(8 * 50000);
        err_count++;
        final_report();
    end

    //----------------------------------------------------------------------
    // main sequence
    //----------------------------------------------------------------------
    initial begin
        logic [31:0] w3, w2, d3, d2, k, e3, e2;
        logic [2:0] oe3, p3;
        logic [1:0] oe2, p2;
        repeat (20) @(posedge i_core_clk);
        i_rst <= 1'b0;
        void'($urandom(32'h08173491));
        @(posedge i_core_clk);
        check(32'({o_two_oe, o_three_oe}), 32'h0000_0000);
        for (int i = 0; i < 12; i++) begin
            w3 = $urandom;
            w2 = $urandom;
            d3 = $urandom;
            d2 = $urandom;
            k = $urandom;
            e3 = $urandom;
            e2 = $urandom;
            ext3 <= e3[2:0];
            ext2 <= e2[1:0];
            wr(gkp_pkg::GKP_ADDR_THREE_DATA, w3);
            wr(gkp_pkg::GKP_ADDR_TWO_DATA, w2);
            wr(gkp_pkg::GKP_ADDR_THREE_DIR, d3);
            wr(gkp_pkg::GKP_ADDR_TWO_DIR, d2);
            wr(gkp_pkg::GKP_ADDR_KPD_EN, k);
            settle();
            oe3 = d3[2:0] & ~k[2:0];
            oe2 = d2[1:0] & ~k[4:3];
            p3 = (oe3 & w3[2:0]) | (~oe3 & e3[2:0]);
            p2 = (oe2 & w2[1:0]) | (~oe2 & e2[1:0]);
            check(32'(o_three_oe), 32'(oe3));
            check(32'(o_two_oe), 32'(oe2));
            check(32'({o_two_out, o_three_out}), 32'({w2[1:0], w3[2:0]}));
            check(32'(o_kpd_pin), 32'({p2, p3}));
            check(32'(o_kpd_en), 32'(k[4:0]));
            rd(gkp_pkg::GKP_ADDR_THREE_DATA, 32'((d3[2:0] & w3[2:0]) | (~d3[2:0] & p3)));
            rd(gkp_pkg::GKP_ADDR_TWO_DATA, 32'((d2[1:0] & w2[1:0]) | (~d2[1:0] & p2)));
            rd(gkp_pkg::GKP_ADDR_THREE_DIR, 32'(d3[2:0]));
            rd(gkp_pkg::GKP_ADDR_TWO_DIR, 32'(d2[1:0]));
        end
        apb(1'b1, gkp_pkg::GKP_ADDR_THREE_DIR, ~d3, 4'h0, 32'h0000_0000, 1'b0);
        rd(gkp_pkg::GKP_ADDR_THREE_DIR, 32'(d3[2:0]));
        apb(1'b1, 8'h80, 32'hFFFF_FFFF, 4'hF, 32'h0000_0000, 1'b1);
        apb(1'b0, 8'h80, 32'h0000_0000, 4'hF, 32'h0000_0000, 1'b1);
        // second reset in mid-run: directions clear, latches must survive
        @(posedge i_core_clk);
        i_rst <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        i_rst <= 1'b0;
        @(posedge i_core_clk);
        check(32'({o_two_oe, o_three_oe}), 32'h0000_0000);
        rd(gkp_pkg::GKP_ADDR_THREE_DIR, 32'h0000_0000);
        rd(gkp_pkg::GKP_ADDR_TWO_DIR, 32'h0000_0000);
        settle();
        rd(gkp_pkg::GKP_ADDR_THREE_DATA, 32'(e3[2:0]));
        wr(gkp_pkg::GKP_ADDR_KPD_EN, 32'h0000_001F);
        wr(gkp_pkg::GKP_ADDR_THREE_DIR, 32'h0000_0007);
        wr(gkp_pkg::GKP_ADDR_TWO_DIR, 32'h0000_0003);
        settle();
        rd(gkp_pkg::GKP_ADDR_THREE_DATA, 32'(w3[2:0]));
        rd(gkp_pkg::GKP_ADDR_TWO_DATA, 32'(w2[1:0]));
        settle();
        final_report();
    end
endmodule : tb
